// ### core/amp_state_pkg.sv
// Package: states, register map, field positions and timing for the state machine
package amp_state_pkg;

    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_IDLE,
        ST_AMP_RAMP,
        ST_AMP_ON,
        ST_TURNON_DIAG,
        ST_PERM_DIAG
    } op_state_t;

    // Register byte offsets
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] DIAG_OFS   = 12'h008;
    localparam logic [11:0] RES_OFS    = 12'h00C;

    // Control field positions
    localparam int AMP_ON_POS     = 0;
    localparam int DIAG_EN_POS    = 1;
    localparam int REAR_PLAY_POS  = 3;
    localparam int FRONT_PLAY_POS = 4;
    localparam int TW_SEL_POS     = 6;
    localparam int DIAG_START_POS = 0;

    localparam logic [7:0] CTRL_RST = 8'h00;

    // Ramp and diagnostic durations
    localparam int CLK_HZ       = 20_000_000;
    localparam int RAMP_MS      = 2;
    localparam int RAMP_CYCLES  = RAMP_MS * (CLK_HZ / 1000);
    localparam int DIAG_US      = 100;
    localparam int DIAG_CYCLES  = DIAG_US * (CLK_HZ / 1_000_000);
    localparam int SCLK_TMO_US  = 10;
    localparam int SCLK_TMO_CYC = SCLK_TMO_US * (CLK_HZ / 1_000_000);

    // Thermal-warning offsets below protection temperature, degrees
    localparam logic [7:0] TW_OFS0 = 8'h05;
    localparam logic [7:0] TW_OFS1 = 8'h0A;
    localparam logic [7:0] TW_OFS2 = 8'h14;
    localparam logic [7:0] TW_OFS3 = 8'h1E;

    typedef struct packed {
        logic       amp_on;
        logic       diag_en;
        logic       front_play;
        logic       rear_play;
        logic [1:0] tw_sel;
    } ctrl_t;

    typedef struct packed {
        logic low_batt;
        logic over_volt;
        logic lock_loss;
        logic thermal;
        logic supply_lt_8v;
        logic overcurrent;
    } cond_t;

endpackage

// ### core/sync2.sv
// Two-flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module sync2 (
    input  wire logic sys_clk_i,    // System clock
    input  wire logic reset_n_i,    // Synchronous reset, active low
    input  wire logic async_i,      // Asynchronous level
    output logic      sync_o        // Synchronised level
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// ### core/tw_compare.sv
// Thermal-warning threshold compare
`timescale 1ns/1ps
module tw_compare
    import amp_state_pkg::*;
(
    input  wire logic       sys_clk_i,   // System clock
    input  wire logic       reset_n_i,   // Synchronous reset, active low
    input  wire logic [1:0] sel_i,       // Threshold select
    input  wire logic [7:0] temp_i,      // Junction temperature, degrees
    input  wire logic [7:0] tprot_i,     // Protection temperature
    output logic            warn_o       // Thermal warning
);
    logic [7:0] ofs;
    logic [7:0] thr;
    logic       warn_q;

    always_comb begin
        unique case (sel_i)
            2'h0: ofs = TW_OFS0;
            2'h1: ofs = TW_OFS1;
            2'h2: ofs = TW_OFS2;
            2'h3: ofs = TW_OFS3;
        endcase
        thr = tprot_i - ofs;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            warn_q <= 1'b0;
        end else begin
            warn_q <= (temp_i >= thr);
        end
    end

    assign warn_o = warn_q;
endmodule

// ### core/amp_operating_state_fsm.sv
// Operating-state machine of a quad audio amplifier with APB control
`timescale 1ns/1ps

// Notes on behaviour
// - Six states: standby, idle, amplifier ramp, amplifier on, two diagnostic kinds.
// - Standby pin low keeps the device in standby, nothing active; here APB reads and tw_o still work.
// - Standby pin high enters low-power idle and accepts host commands.
// - Short-circuit protection stays enabled in low-power idle.
// - Idle holds speaker outputs and analog regulator off, zero volts.
// - Amplifier mode needs amp-on bit set and serial clock present.
// - Entering amplifier mode ramps bias from zero to half supply.
// - Front and rear play bits switch each pair between mute and play.
// - Hardware unmute input: low forces mute, high allows play.
// - Turn-on diagnostic runs only from low-power idle.
// - Overcurrent in play starts permanent diagnostic by itself.
// - Two-bit select sets warning at protection minus 5, 10, 20, 30.
// - Diagnostic starts on rising diag-enable edge while amp-on is zero.
// - No turn-on diagnostic below 8 V or under any mute condition.
// - Reading fourth result byte clears all four result bytes.
module amp_operating_state_fsm (
    input  wire logic                       sys_clk_i,    // 20 MHz clock
    input  wire logic                       reset_n_i,    // Sync reset, low
    input  wire logic                       psel_i,       // APB select
    input  wire logic                       penable_i,    // APB enable
    input  wire logic                       pwrite_i,     // APB write
    input  wire logic [11:0]                paddr_i,      // APB address
    input  wire logic [31:0]                pwdata_i,     // APB write data
    output logic      [31:0]                prdata_o,     // APB read data
    output logic                            pready_o,     // APB ready
    output logic                            pslverr_o,    // APB error
    input  wire logic                       standby_pin_i,// Standby pin
    input  wire logic                       sclk_i,       // Serial clock pin
    input  wire logic                       hardware_unmute_input_i,  // Hardware unmute
    input  wire logic                       hardware_unmute_input_en_i,// Package has pin
    input  wire amp_state_pkg::cond_t       cond_i,       // Fault conditions
    input  wire logic [7:0]                 temp_i,       // Junction temp
    input  wire logic [7:0]                 tprot_i,      // Protection temp
    input  wire logic [31:0]                diag_res_i,   // Four result bytes
    output amp_state_pkg::op_state_t        state_o,      // Current state
    output logic                            prot_en_o,    // Short protection
    output logic                            reg_on_o,     // Analog regulator
    output logic                            outputs_en_o, // Output stage on
    output logic                            ramp_o,       // Bias ramping
    output logic                            front_play_o, // Front pair playing
    output logic                            rear_play_o,  // Rear pair playing
    output logic                            tw_o          // Thermal warning
);
    import amp_state_pkg::*;

    // ***************************************************
    // Pin synchronisers
    // ***************************************************
    logic standby_pin_s;
    logic sclk_s;
    logic unmute_s;

    sync2 u_sync_standby_pin (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (standby_pin_i),
        .sync_o    (standby_pin_s)
    );
    sync2 u_sync_sclk (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (sclk_i),
        .sync_o    (sclk_s)
    );
    sync2 u_sync_unm (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (hardware_unmute_input_i),
        .sync_o    (unmute_s)
    );

    // ***************************************************
    // Serial clock presence detector
    // ***************************************************
    // Any edge within the timeout counts as a running clock
    logic        sclk_d1_q;
    logic [15:0] sclk_tmo_q;
    logic        sclk_ok;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            sclk_d1_q  <= 1'b0;
            sclk_tmo_q <= 16'h0000;
        end else begin
            sclk_d1_q <= sclk_s;
            if (sclk_s != sclk_d1_q) begin
                sclk_tmo_q <= 16'(SCLK_TMO_CYC);
            end else if (sclk_tmo_q != 16'h0000) begin
                sclk_tmo_q <= sclk_tmo_q - 16'h0001;
            end
        end
    end
    assign sclk_ok = (sclk_tmo_q != 16'h0000);

    // ***************************************************
    // APB register file
    // ***************************************************
    ctrl_t       ctrl_q;
    logic [31:0] res_q;
    logic        res_valid_q;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    op_state_t   state_q;
    logic        diag_done;

    assign addr_ok = (paddr_i == CTRL_OFS) || (paddr_i == STATUS_OFS) ||
                     (paddr_i == DIAG_OFS) || (paddr_i == RES_OFS);
    assign wr_en     = psel_i && penable_i && pwrite_i && addr_ok;
    assign rd_en     = psel_i && penable_i && !pwrite_i && addr_ok;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i || !standby_pin_s) begin
            ctrl_q <= ctrl_t'(6'(CTRL_RST));
        end else if (wr_en && paddr_i == CTRL_OFS) begin
            ctrl_q.amp_on     <= pwdata_i[AMP_ON_POS];
            ctrl_q.front_play <= pwdata_i[FRONT_PLAY_POS];
            ctrl_q.rear_play  <= pwdata_i[REAR_PLAY_POS];
            ctrl_q.tw_sel     <= pwdata_i[TW_SEL_POS +: 2];
        end else if (wr_en && paddr_i == DIAG_OFS) begin
            // Own word, so control writes never make a false start edge
            ctrl_q.diag_en    <= pwdata_i[DIAG_START_POS];
        end
    end

    always_comb begin
        prdata_o = 32'h0000_0000;
        if (rd_en) begin
            unique case (paddr_i)
                CTRL_OFS:   prdata_o = {24'h000000, ctrl_q.tw_sel, 1'b0,
                                        ctrl_q.front_play, ctrl_q.rear_play,
                                        1'b0, ctrl_q.diag_en, ctrl_q.amp_on};
                STATUS_OFS: prdata_o = {24'h000000, tw_o, sclk_ok,
                                        1'b0, res_valid_q, 1'b0,
                                        3'(state_q)};
                DIAG_OFS:   prdata_o = {31'h0, ctrl_q.diag_en};
                RES_OFS:    prdata_o = res_q;
                default:    prdata_o = 32'h0000_0000;
            endcase
        end
    end

    // ***************************************************
    // Mute conditions and diagnostic start
    // ***************************************************
    logic hw_mute;
    logic any_mute;
    logic diag_en_d1_q;
    logic diag_rise;
    logic diag_start;

    assign hw_mute  = hardware_unmute_input_en_i && !unmute_s;
    assign any_mute = cond_i.low_batt || cond_i.over_volt ||
                      cond_i.lock_loss || cond_i.thermal || hw_mute;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            diag_en_d1_q <= 1'b0;
        end else begin
            diag_en_d1_q <= ctrl_q.diag_en;
        end
    end
    assign diag_rise  = ctrl_q.diag_en && !diag_en_d1_q;
    assign diag_start = diag_rise && !ctrl_q.amp_on &&
                        !cond_i.supply_lt_8v && !any_mute;

    // ***************************************************
    // Operating state machine
    // ***************************************************
    op_state_t   state_d;
    logic [17:0] tmr_q;
    logic        tmr_zero;

    assign tmr_zero = (tmr_q == 18'h00000);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_STANDBY:
                if (standby_pin_s) state_d = ST_IDLE;
            ST_IDLE:
                if (diag_start) state_d = ST_TURNON_DIAG;
                else if (ctrl_q.amp_on && sclk_ok)
                    state_d = ST_AMP_RAMP;
            ST_AMP_RAMP:
                if (!ctrl_q.amp_on) state_d = ST_IDLE;
                else if (tmr_zero) state_d = ST_AMP_ON;
            ST_AMP_ON:
                if (!ctrl_q.amp_on) state_d = ST_IDLE;
                else if (cond_i.overcurrent &&
                         (front_play_o || rear_play_o))
                    state_d = ST_PERM_DIAG;
            ST_TURNON_DIAG:
                if (tmr_zero) state_d = ST_IDLE;
            ST_PERM_DIAG:
                if (tmr_zero) state_d = ST_AMP_ON;
        endcase
        if (!standby_pin_s) begin
            state_d = ST_STANDBY;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            state_q <= ST_STANDBY;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            tmr_q <= 18'h00000;
        end else if (state_d != state_q) begin
            unique case (state_d)
                ST_AMP_RAMP:    tmr_q <= 18'(RAMP_CYCLES - 1);
                ST_TURNON_DIAG,
                ST_PERM_DIAG:   tmr_q <= 18'(DIAG_CYCLES - 1);
                default:        tmr_q <= 18'h00000;
            endcase
        end else if (!tmr_zero) begin
            tmr_q <= tmr_q - 18'h00001;
        end
    end
    assign diag_done = (state_q == ST_TURNON_DIAG) && tmr_zero;

    // ***************************************************
    // Diagnostic result bytes
    // ***************************************************
    // Results are latched at the end of the turn-on run
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i || !standby_pin_s) begin
            res_q       <= 32'h0000_0000;
            res_valid_q <= 1'b0;
        end else if (diag_done) begin
            res_q       <= diag_res_i;
            res_valid_q <= 1'b1;
        end else if (rd_en && paddr_i == RES_OFS) begin
            res_q       <= 32'h0000_0000;
            res_valid_q <= 1'b0;
        end
    end

    // ***************************************************
    // Outputs
    // ***************************************************
    logic amp_live;
    assign amp_live = (state_q == ST_AMP_ON);

    assign state_o      = state_q;
    assign prot_en_o    = (state_q != ST_STANDBY);
    assign reg_on_o     = (state_q == ST_AMP_RAMP) || amp_live ||
                          (state_q == ST_PERM_DIAG);
    assign outputs_en_o = reg_on_o;
    assign ramp_o       = (state_q == ST_AMP_RAMP);
    assign front_play_o = amp_live && ctrl_q.front_play &&
                          !hw_mute;
    assign rear_play_o  = amp_live && ctrl_q.rear_play &&
                          !hw_mute;

    tw_compare u_tw (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .sel_i     (ctrl_q.tw_sel),
        .temp_i    (temp_i),
        .tprot_i   (tprot_i),
        .warn_o    (tw_o)
    );

    // ***************************************************
    // Assertions
    // ***************************************************
    property p_standby_hold;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !standby_pin_s |=> state_q == ST_STANDBY && !reg_on_o;
    endproperty
    a_standby_hold: assert property (p_standby_hold)
        else $error("not in standby while pin low");

    property p_wake_idle;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q == ST_STANDBY && standby_pin_s |=> state_q == ST_IDLE;
    endproperty
    a_wake_idle: assert property (p_wake_idle)
        else $error("standby did not wake to idle");

    property p_idle_off;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q == ST_IDLE |-> !reg_on_o && prot_en_o;
    endproperty
    a_idle_off: assert property (p_idle_off)
        else $error("idle with regulator on");

    property p_amp_entry;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(state_q == ST_AMP_RAMP) |->
            $past(ctrl_q.amp_on) && $past(sclk_ok);
    endproperty
    a_amp_entry: assert property (p_amp_entry)
        else $error("amplifier entered without amp-on and clock");

    property p_diag_gate;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(state_q == ST_TURNON_DIAG) |->
            $past(state_q) == ST_IDLE && !$past(ctrl_q.amp_on);
    endproperty
    a_diag_gate: assert property (p_diag_gate)
        else $error("turn-on diagnostic from wrong state");

    property p_diag_block;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (cond_i.supply_lt_8v || any_mute) && standby_pin_s |=>
            !$rose(state_q == ST_TURNON_DIAG);
    endproperty
    a_diag_block: assert property (p_diag_block)
        else $error("diagnostic started under mute");

    property p_perm;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        amp_live && cond_i.overcurrent && front_play_o && standby_pin_s &&
            ctrl_q.amp_on |=> state_q == ST_PERM_DIAG;
    endproperty
    a_perm: assert property (p_perm)
        else $error("overcurrent missed permanent diagnostic");

    property p_hw_mute;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        hw_mute |-> !front_play_o && !rear_play_o;
    endproperty
    a_hw_mute: assert property (p_hw_mute)
        else $error("play while hardware mute");

    property p_res_clear;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        rd_en && paddr_i == RES_OFS && !diag_done && standby_pin_s |=>
            res_q == 32'h0000_0000;
    endproperty
    a_res_clear: assert property (p_res_clear)
        else $error("results not cleared after read");
endmodule

// ### bench/host_model.sv
// Host controller model: APB master and serial audio clock source
`timescale 1ns/1ps
module host_model (
    input  wire logic        sys_clk_i, // System clock
    output logic             psel_o,    // APB select
    output logic             penable_o, // APB enable
    output logic             pwrite_o,  // APB write
    output logic [11:0]      paddr_o,   // APB address
    output logic [31:0]      pwdata_o,  // APB write data
    input  wire logic [31:0] prdata_i,  // APB read data
    input  wire logic        pready_i,  // APB ready
    input  wire logic        pslverr_i, // APB error
    output logic             sclk_o     // Serial audio clock
);
    logic        sclk_run = 1'b0;
    logic [31:0] rd;
    logic        err;
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0;
    end
    // Clock stands low when stopped, as a real source that is switched off
    always @(posedge sys_clk_i) begin
        sclk_o <= sclk_run ? ~sclk_o : 1'b0;
    end
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge sys_clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        do @(posedge sys_clk_i); while (pready_i !== 1'b1);
        rd = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Released lines carry garbage so stale values cannot pass
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for the amplifier operating-state machine
`timescale 1ns/1ps
module testbench;
    import amp_state_pkg::*;
    logic        sys_clk_i, reset_n_i, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, res;
    logic        pready, pslverr, standby, sclk, hardware_unmute_input, unmute_en;
    cond_t       cond;
    logic [7:0]  temp, tprot;
    op_state_t   state;
    logic        prot_en, reg_on, outs_en, ramp, front, rear, tw;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    logic [7:0]  offs [4] = '{8'h05, 8'h0A, 8'h14, 8'h1E};

    host_model host (.sys_clk_i(sys_clk_i), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr), .sclk_o(sclk));
    amp_operating_state_fsm i_amp_operating_state_fsm (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .standby_pin_i(standby), .sclk_i(sclk),
        .hardware_unmute_input_i(hardware_unmute_input), .hardware_unmute_input_en_i(unmute_en), .cond_i(cond),
        .temp_i(temp), .tprot_i(tprot), .diag_res_i(res),
        .state_o(state), .prot_en_o(prot_en), .reg_on_o(reg_on),
        .outputs_en_o(outs_en), .ramp_o(ramp), .front_play_o(front),
        .rear_play_o(rear), .tw_o(tw));

    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // Whole run needs about 45000 cycles, one ramp included
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk_word(input string n, input logic [31:0] e,
                            input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        chk_word(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic wait_st(input op_state_t s, input int lim);
        int n;
        n = 0;
        @(negedge sys_clk_i);
        while (state !== s && n < lim) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk_word("state", {29'h0, s}, {29'h0, state});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d);
    endtask
    task automatic rdc(input string n, input logic [11:0] a,
                       input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0);
        chk_word(n, e, host.rd);
    endtask
    task automatic pulse_diag;
        wr(DIAG_OFS, 32'h0);
        wr(DIAG_OFS, 32'h1);
        idle(10);
    endtask

    task automatic t_standby;
        idle(20);
        wait_st(ST_STANDBY, 0);
        chk_bit("prot_en", 1'b0, prot_en);
        rdc("ctrl", CTRL_OFS, 32'h0);
        $display("test standby done");
    endtask
    task automatic t_idle;
        @(posedge sys_clk_i);
        standby <= 1'b1;
        wait_st(ST_IDLE, 10);
        chk_bit("prot_en", 1'b1, prot_en);
        chk_bit("reg_on", 1'b0, reg_on);
        chk_bit("outs_en", 1'b0, outs_en);
        host.xfer(1'b0, 12'h010, 32'h0);
        chk_bit("slverr", 1'b1, host.err);
        wr(CTRL_OFS, 32'h1);
        idle(400);
        wait_st(ST_IDLE, 0);
        wr(CTRL_OFS, 32'h0);
        $display("test idle done");
    endtask
    task automatic t_warn;
        for (int s = 0; s < 4; s++) begin
            wr(CTRL_OFS, {24'h0, 2'(s), 6'h00});
            temp <= tprot - offs[s];
            idle(3);
            chk_bit("tw", 1'b1, tw);
            @(posedge sys_clk_i);
            temp <= tprot - offs[s] - 8'h01;
            idle(3);
            chk_bit("tw", 1'b0, tw);
        end
        $display("test warn done");
    endtask
    task automatic t_diag;
        // Case 0 is the hardware mute, the others one fault level each
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk_i);
            hardware_unmute_input <= (i != 0);
            cond <= cond_t'(6'(i == 0 ? 0 : 1 << i));
            idle(5);
            pulse_diag();
            wait_st(ST_IDLE, 0);
        end
        @(posedge sys_clk_i);
        cond <= '0;
        hardware_unmute_input <= 1'b1;
        idle(5);
        wr(DIAG_OFS, 32'h0);
        wr(DIAG_OFS, 32'h1);
        wait_st(ST_TURNON_DIAG, 5);
        wait_st(ST_IDLE, DIAG_CYCLES + 10);
        rdc("diag", DIAG_OFS, 32'h1);
        rdc("res", RES_OFS, res);
        rdc("res", RES_OFS, 32'h0);
        $display("test diag done");
    endtask
    task automatic t_amp;
        host.sclk_run = 1'b1;
        wr(CTRL_OFS, 32'h1);
        wait_st(ST_AMP_RAMP, 300);
        chk_bit("ramp", 1'b1, ramp);
        chk_bit("reg_on", 1'b1, reg_on);
        wait_st(ST_AMP_ON, RAMP_CYCLES + 10);
        for (int k = 0; k < 4; k++) begin
            wr(CTRL_OFS, {27'h0, 2'(k), 3'b001});
            idle(3);
            chk_bit("front", k[1], front);
            chk_bit("rear", k[0], rear);
        end
        @(posedge sys_clk_i);
        hardware_unmute_input <= 1'b0;
        idle(6);
        chk_bit("front", 1'b0, front);
        chk_bit("rear", 1'b0, rear);
        @(posedge sys_clk_i);
        hardware_unmute_input <= 1'b1;
        idle(6);
        chk_bit("front", 1'b1, front);
        @(posedge sys_clk_i);
        unmute_en <= 1'b0;
        hardware_unmute_input <= 1'b0;
        idle(6);
        chk_bit("front", 1'b1, front);
        @(posedge sys_clk_i);
        unmute_en <= 1'b1;
        hardware_unmute_input <= 1'b1;
        idle(6);
        pulse_diag();
        wait_st(ST_AMP_ON, 0);
        $display("test amp done");
    endtask
    task automatic t_perm;
        @(posedge sys_clk_i);
        cond <= cond_t'(6'h01);
        wait_st(ST_PERM_DIAG, 10);
        @(posedge sys_clk_i);
        cond <= '0;
        wait_st(ST_AMP_ON, DIAG_CYCLES + 10);
        $display("test perm done");
    endtask
    task automatic t_exit;
        wr(CTRL_OFS, 32'h0);
        wait_st(ST_IDLE, 10);
        chk_bit("outs_en", 1'b0, outs_en);
        host.sclk_run = 1'b0;
        @(posedge sys_clk_i);
        standby <= 1'b0;
        wait_st(ST_STANDBY, 10);
        rdc("ctrl", CTRL_OFS, 32'h0);
        $display("test exit done");
    endtask

    initial begin
        reset_n_i = 1'b0;
        standby = 1'b0;
        hardware_unmute_input = 1'b1;
        unmute_en = 1'b1;
        cond = '0;
        temp = 8'h00;
        tprot = 8'h9B;
        res = 32'h5A3C96E1;
        repeat (5) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        t_standby();
        t_idle();
        t_warn();
        t_diag();
        t_amp();
        t_perm();
        t_exit();
        final_report();
    end
endmodule
